//--- shared/bco_map.svh
`ifndef BCO_MAP_SVH
`define BCO_MAP_SVH

// Cycle status codes, bit2..bit0
`define BCO_ST_INTA      3'h0
`define BCO_ST_IORD      3'h1
`define BCO_ST_IOWR      3'h2
`define BCO_ST_HALT      3'h3
`define BCO_ST_FETCH     3'h4
`define BCO_ST_MEMRD     3'h5
`define BCO_ST_MEMWR     3'h6
`define BCO_ST_PASSIVE   3'h7

// Queue status codes, bit1..bit0
`define BCO_QS_NONE      2'h0
`define BCO_QS_FIRST     2'h1
`define BCO_QS_EMPTY     2'h2
`define BCO_QS_NEXT      2'h3

// Bus cycle phase state codes
`define BCO_PH_IDLE      3'h0
`define BCO_PH_T1        3'h1
`define BCO_PH_T2        3'h2
`define BCO_PH_T3        3'h3
`define BCO_PH_T4        3'h4

// Field positions of the 20-bit cycle address
`define BCO_UPPER_HI     19
`define BCO_UPPER_LO     16
`define BCO_MID_HI       15
`define BCO_MID_LO       8

// Pin values outside a cycle and at reset
`define BCO_UPPER_IDLE   4'h0
`define BCO_MID_IDLE     8'h0
`define BCO_ALE_RESET    1'h0

`endif

//--- shared/bco_pkg.sv
`include "bco_map.svh"

package bco_pkg;

    // Kind of bus cycle the core starts
    typedef enum logic [2:0] {
        BCO_INTA    = `BCO_ST_INTA,
        BCO_IORD    = `BCO_ST_IORD,
        BCO_IOWR    = `BCO_ST_IOWR,
        BCO_HALT    = `BCO_ST_HALT,
        BCO_FETCH   = `BCO_ST_FETCH,
        BCO_MEMRD   = `BCO_ST_MEMRD,
        BCO_MEMWR   = `BCO_ST_MEMWR,
        BCO_PASSIVE = `BCO_ST_PASSIVE
    } bco_status_type;

    // Queue operation reported in queue status mode
    typedef enum logic [1:0] {
        BCO_QNONE  = `BCO_QS_NONE,
        BCO_QFIRST = `BCO_QS_FIRST,
        BCO_QEMPTY = `BCO_QS_EMPTY,
        BCO_QNEXT  = `BCO_QS_NEXT
    } bco_queue_type;

    // Bus cycle phases
    typedef enum logic [2:0] {
        BCO_IDLE = `BCO_PH_IDLE,
        BCO_T1   = `BCO_PH_T1,
        BCO_T2   = `BCO_PH_T2,
        BCO_T3   = `BCO_PH_T3,
        BCO_T4   = `BCO_PH_T4
    } bco_state_type;

    // One bus cycle request from the core
    typedef struct packed {
        logic [19:0]    addr;       // Full 20-bit address
        bco_status_type code;       // Cycle status code
        logic           dmaCycle;   // DMA or refresh, not CPU
    } bco_cycle_type;

endpackage

//--- rtl/bco_pin_reg.sv
`timescale 1ns/10ps

// Registered output pin group with its drive enable
module bco_pin_reg #(
    parameter int              W      = 4,
    parameter logic [W-1:0]    RSTVAL = '0
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // Next values from the owner
    input  wire logic [W-1:0]  dataNext,
    input  wire logic          oeNext,
    // Pin side
    output logic      [W-1:0]  pinOut,
    output logic               pinOe
);

    logic [W-1:0] data_reg;   // Pin level
    logic [W-1:0] data_next;
    logic         oe_reg;     // Drive enable
    logic         oe_next;

    // Reset floats the group at its reset level
    always_comb begin
        data_next = dataNext;
        oe_next   = oeNext;
        if (srst) begin
            data_next = RSTVAL;
            oe_next   = 1'b0;
        end
    end

    // Plain registers, so the pins never glitch
    always_ff @(posedge clk) begin
        data_reg <= data_next;
        oe_reg   <= oe_next;
    end

    assign pinOut = data_reg;
    assign pinOe  = oe_reg;

endmodule

//--- rtl/bco_bus_outputs.sv
`timescale 1ns/10ps

module bco_bus_outputs
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Cycle request from the core
    input  wire logic                 cycStart,
    input  wire bco_pkg::bco_cycle_type cycInfo,
    output logic                      cycReady,
    // Modes from the core
    input  wire logic                 byteBus,
    input  wire logic                 queueMode,
    input  wire bco_pkg::bco_queue_type queueOp,
    input  wire logic                 busHold,
    input  wire logic                 powerDown,
    // Upper address / origin flag pins
    output logic [3:0]                upperAddrPins,
    output logic                      upperAddrOe,
    // Byte-bus address bits 15..8
    output logic [7:0]                addrBits15_8,
    output logic                      addrBits15_8Oe,
    // Cycle status pins
    output logic [2:0]                cycleStatusCode,
    output logic                      cycleStatusOe,
    // Strobe / queue pins
    output logic                      aleQs0Pin,
    output logic                      queueStatBit1
);
    import bco_pkg::*;

    bco_state_type state_reg;     // Bus cycle phase
    bco_state_type state_next;
    bco_cycle_type cyc_reg;       // Cycle in flight
    bco_cycle_type cyc_next;
    logic          ready_reg;     // Request window
    logic          ready_next;
    logic          ale_reg;       // Strobe or queue bit0
    logic          ale_next;
    logic          qs1_reg;       // Queue bit1
    logic          qs1_next;
    logic          take;          // Request accepted
    logic          stall;         // Hold or powerdown
    logic [3:0]    upperNext;
    logic          upperOeNext;
    logic [7:0]    midNext;
    logic          midOeNext;
    logic [2:0]    statNext;
    logic          statOeNext;

    // Phase sequencing: T1 address, T2..T4 data
    always_comb begin
        stall      = busHold | powerDown;
        take       = cycStart & ready_reg;
        state_next = state_reg;
        cyc_next   = cyc_reg;
        unique case (state_reg)
            BCO_IDLE: if (take) state_next = BCO_T1;
            BCO_T1:   state_next = BCO_T2;
            BCO_T2:   state_next = BCO_T3;
            BCO_T3:   state_next = BCO_T4;
            BCO_T4:   state_next = take ? BCO_T1 : BCO_IDLE;
            default:  state_next = BCO_IDLE;
        endcase
        if (take) begin
            cyc_next = cycInfo;
        end
        // Another master or powerdown ends any cycle
        if (stall | srst) begin
            state_next = BCO_IDLE;
        end
        ready_next = ~stall & ~srst &
            (state_next == BCO_IDLE || state_next == BCO_T4);
    end

    // Pin values follow the phase being entered
    always_comb begin
        upperNext   = `BCO_UPPER_IDLE;
        upperOeNext = 1'b1;
        midNext     = `BCO_MID_IDLE;
        midOeNext   = byteBus;
        statNext    = `BCO_ST_PASSIVE;
        statOeNext  = 1'b1;
        ale_next    = 1'b0;
        qs1_next    = 1'b0;
        unique case (state_next)
            BCO_T1: begin
                // Address bits for the external latch
                upperNext = cyc_next.addr[`BCO_UPPER_HI:`BCO_UPPER_LO];
                statNext  = cyc_next.code;
                ale_next  = 1'b1;
            end
            BCO_T2, BCO_T3, BCO_T4: begin
                // Origin flag on bit 19, low bits zero
                upperNext = {cyc_next.dmaCycle, 3'h0};
                if (state_next == BCO_T2) begin
                    statNext = cyc_next.code;
                end
            end
            default: begin
                upperNext = `BCO_UPPER_IDLE;
            end
        endcase
        if (state_next != BCO_IDLE) begin
            // Byte bus holds bits 15..8 through T4
            midNext = cyc_next.addr[`BCO_MID_HI:`BCO_MID_LO];
        end
        if (queueMode) begin
            // Strobe pin repurposed for queue status
            ale_next = queueOp[0];
            qs1_next = queueOp[1];
        end
        if (busHold) begin
            upperOeNext = 1'b0;
            midOeNext   = 1'b0;
            statOeNext  = 1'b0;
            ale_next    = 1'b0;
        end
        if (powerDown) begin
            // Address pins keep their last level
            upperNext   = upperAddrPins;
            upperOeNext = upperAddrOe;
            midNext     = addrBits15_8;
            midOeNext   = addrBits15_8Oe;
            statNext    = `BCO_ST_PASSIVE;
            statOeNext  = 1'b1;
            ale_next    = 1'b0;
        end
        if (srst) begin
            ale_next = `BCO_ALE_RESET;
        end
    end

    // Phase and strobe registers
    always_ff @(posedge clk) begin
        state_reg <= state_next;
        cyc_reg   <= cyc_next;
        ready_reg <= ready_next;
        ale_reg   <= ale_next;
        qs1_reg   <= qs1_next;
    end

    // Pin groups; reset floats each of them
    bco_pin_reg #(.W(4), .RSTVAL(`BCO_UPPER_IDLE)) upperPin (
        .clk      (clk),
        .srst     (srst),
        .dataNext (upperNext),
        .oeNext   (upperOeNext),
        .pinOut   (upperAddrPins),
        .pinOe    (upperAddrOe)
    );

    bco_pin_reg #(.W(8), .RSTVAL(`BCO_MID_IDLE)) midPin (
        .clk      (clk),
        .srst     (srst),
        .dataNext (midNext),
        .oeNext   (midOeNext),
        .pinOut   (addrBits15_8),
        .pinOe    (addrBits15_8Oe)
    );

    bco_pin_reg #(.W(3), .RSTVAL(`BCO_ST_PASSIVE)) statPin (
        .clk      (clk),
        .srst     (srst),
        .dataNext (statNext),
        .oeNext   (statOeNext),
        .pinOut   (cycleStatusCode),
        .pinOe    (cycleStatusOe)
    );

    assign cycReady      = ready_reg;
    assign aleQs0Pin     = ale_reg;
    assign queueStatBit1 = qs1_reg;

    // Checks beside the logic
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence dataPhases;
        state_reg == BCO_T2 ##1 state_reg == BCO_T3 ##1 state_reg == BCO_T4;
    endsequence

    addr_phase_a: assert property (
        state_reg == BCO_T1 && !powerDown |->
        upperAddrPins == cyc_reg.addr[19:16])
        else $error("upper address wrong in address phase");

    data_zero_a: assert property (
        state_reg == BCO_T1 ##1 dataPhases |->
        upperAddrPins[2:0] == 3'h0)
        else $error("bits 18..16 not zero in data phase");

    mid_stable_a: assert property (
        byteBus && state_reg == BCO_T1 ##1 dataPhases |->
        addrBits15_8 == cyc_reg.addr[15:8] && addrBits15_8Oe
        && $stable(addrBits15_8))
        else $error("bits 15..8 not held through cycle");

    origin_flag_a: assert property (
        state_reg == BCO_T2 && !powerDown |->
        upperAddrPins[3] == cyc_reg.dmaCycle)
        else $error("origin flag wrong");

    status_code_a: assert property (
        state_reg == BCO_T1 |-> cycleStatusCode == cyc_reg.code
        ##2 cycleStatusCode == `BCO_ST_PASSIVE)
        else $error("status code sequence wrong");

    strobe_pulse_a: assert property (
        $rose(state_reg == BCO_T1) && !queueMode && !busHold
        && !powerDown |-> aleQs0Pin ##1 !aleQs0Pin || queueMode)
        else $error("latch strobe not one address phase");

    queue_bits_a: assert property (
        $past(queueMode) && !$past(busHold) && !$past(powerDown)
        |-> {queueStatBit1, aleQs0Pin} == $past(queueOp))
        else $error("queue status bits wrong");

    // Powerdown wins the status pins, so hold alone floats them
    hold_float_a: assert property (
        $past(busHold) && !$past(powerDown) |->
        !upperAddrOe && !cycleStatusOe && !aleQs0Pin)
        else $error("pins not floated in hold");

    hold_power_a: assert property (
        $past(busHold) && $past(powerDown) |->
        cycleStatusOe && cycleStatusCode == `BCO_ST_PASSIVE
        && !aleQs0Pin && $stable(upperAddrPins))
        else $error("hold during powerdown pin states wrong");

    powerdown_a: assert property (
        $past(powerDown) && !$past(busHold) |->
        cycleStatusOe && cycleStatusCode == `BCO_ST_PASSIVE
        && !aleQs0Pin && $stable(upperAddrPins))
        else $error("powerdown pin states wrong");

    reset_a: assert property (
        disable iff (1'b0) srst |=>
        !aleQs0Pin && !cycleStatusOe && !upperAddrOe && !cycReady)
        else $error("reset pin states wrong");

endmodule

//--- bench/bco_addr_latch.sv
`timescale 1ns/10ps

// Board-side latch that holds address bits 19..16 for the decoders
module bco_addr_latch (
    // Bus clock
    input  wire logic       clk,
    // Pins from the device
    input  wire logic       strobe,
    input  wire logic [3:0] pins,
    input  wire logic       pinsOe,
    // Captured address bits 19..16
    output logic      [3:0] latched
);
    logic [3:0] lastSeen = 4'h0; // Last level really driven
    logic [3:0] wireVal;         // Level on the board wires

    // No pull resistors here, so a floating wire shows the inverse
    // of its last level rather than a value the simulator picks
    assign wireVal = pinsOe ? pins : ~lastSeen;

    // Open while the strobe is high; clock sampling stands in for the
    // latch hold time, so the closing edge never races the pins
    always @(posedge clk) begin
        if (pinsOe) begin
            lastSeen <= pins;
        end
        if (strobe) begin
            latched <= wireVal;
        end
    end
endmodule

//--- bench/bco_bus_outputs_bench.sv
`timescale 1ns/10ps

// Self-checking bench for the bus cycle output pins
module bco_bus_outputs_bench;
    import bco_pkg::*;

    // Core-side stimulus, all given a value at time zero
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic          cycStart = 1'b0;
    bco_cycle_type cycInfo = '0;
    logic          byteBus = 1'b1;
    logic          queueMode = 1'b0;
    bco_queue_type queueOp = BCO_QNONE;
    logic          busHold = 1'b0;
    logic          powerDown = 1'b0;
    // Pins and handshake seen from outside
    logic          cycReady, upperAddrOe, addrBits15_8Oe, cycleStatusOe;
    logic          aleQs0Pin, queueStatBit1;
    logic [3:0]    upperAddrPins, latchQ;
    logic [7:0]    addrBits15_8;
    logic [2:0]    cycleStatusCode;
    int            fails = 0;  // Mismatches
    int            checks = 0; // Comparisons made
    int            cycles = 0; // Watchdog count

    // 200 MHz clock
    always #2.5 clk = ~clk;

    bco_bus_outputs dut_u (.clk(clk), .srst(srst), .cycStart(cycStart),
        .cycInfo(cycInfo), .cycReady(cycReady), .byteBus(byteBus),
        .queueMode(queueMode), .queueOp(queueOp), .busHold(busHold),
        .powerDown(powerDown), .upperAddrPins(upperAddrPins),
        .upperAddrOe(upperAddrOe), .addrBits15_8(addrBits15_8),
        .addrBits15_8Oe(addrBits15_8Oe), .cycleStatusCode(cycleStatusCode),
        .cycleStatusOe(cycleStatusOe), .aleQs0Pin(aleQs0Pin),
        .queueStatBit1(queueStatBit1));

    bco_addr_latch latch_u (.clk(clk), .strobe(aleQs0Pin),
        .pins(upperAddrPins), .pinsOe(upperAddrOe), .latched(latchQ));

    // One comparison; four-state so an unknown never matches
    task automatic chk(input string what, input logic [7:0] expv,
                       input logic [7:0] got);
        checks++;
        if (got !== expv) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, expv, got);
        end
    endtask

    // Middle address pins follow the bus width setting
    task automatic mid_chk(input logic [19:0] a);
        chk("mid oe", {7'h0, byteBus}, {7'h0, addrBits15_8Oe});
        if (byteBus) begin
            chk("mid", a[15:8], addrBits15_8);
        end
    endtask

    // One cycle through T3; ends early so the next can chain in T4
    task automatic run_cycle(input logic [19:0] a, input logic [2:0] c,
                             input logic d);
        @(posedge clk);
        cycStart <= 1'b1;
        cycInfo  <= '{a, bco_status_type'(c), d};
        #1 chk("ready", 8'h1, {7'h0, cycReady});
        @(posedge clk);
        cycStart <= 1'b0;
        #1 chk("upper T1", {4'h0, a[19:16]}, {4'h0, upperAddrPins});
        chk("upper oe", 8'h1, {7'h0, upperAddrOe});
        chk("strobe T1", 8'h1, {7'h0, aleQs0Pin});
        chk("status T1", {5'h0, c}, {5'h0, cycleStatusCode});
        mid_chk(a);
        @(posedge clk);
        #1 chk("upper T2", {4'h0, d, 3'h0},
               {4'h0, upperAddrPins});
        chk("strobe T2", 8'h0, {7'h0, aleQs0Pin});
        chk("status T2", {5'h0, c}, {5'h0, cycleStatusCode});
        chk("latched", {4'h0, a[19:16]}, {4'h0, latchQ});
        mid_chk(a);
        @(posedge clk);
        #1 chk("status T3", 8'h7, {5'h0, cycleStatusCode});
        mid_chk(a);
    endtask

    // Every status code, back to back, origin flag alternating
    task automatic test_cycles();
        for (int i = 0; i < 8; i++) begin
            run_cycle({i[3:0] + 4'h8, i[7:0] ^ 8'ha5, 8'h00},
                      i[2:0], i[0]);
        end
        // Width strap moves only on an edge once T4 is launched
        @(posedge clk);
        byteBus <= 1'b0;
        run_cycle(20'hf1234, 3'h5, 1'b1);
        @(posedge clk);
        byteBus <= 1'b1;
        $display("cycles test done");
    endtask

    // Queue codes replace the strobe one edge later
    task automatic test_queue();
        for (int q = 0; q < 4; q++) begin
            @(posedge clk);
            queueMode <= 1'b1;
            queueOp   <= bco_queue_type'(q[1:0]);
            @(posedge clk);
            #1 chk("queue", {6'h0, q[1:0]},
                   {6'h0, queueStatBit1, aleQs0Pin});
        end
        @(posedge clk);
        queueMode <= 1'b0;
        @(posedge clk);
        #1 chk("queue off", 8'h0, {6'h0, queueStatBit1, aleQs0Pin});
        $display("queue test done");
    endtask

    // Hold floats pins; powerdown drives passive status
    task automatic test_hold_power();
        @(posedge clk);
        busHold <= 1'b1;
        @(posedge clk);
        #1 chk("hold oe", 8'h0, {5'h0, upperAddrOe, cycleStatusOe,
            addrBits15_8Oe});
        chk("hold strobe", 8'h0, {7'h0, aleQs0Pin});
        // Let the pins drive again first, so powerdown keeps a driven level
        @(posedge clk);
        busHold <= 1'b0;
        @(posedge clk);
        powerDown <= 1'b1;
        @(posedge clk);
        #1 chk("pd status", 8'hf,
               {4'h0, cycleStatusOe, cycleStatusCode});
        chk("pd upper", 8'h10, {3'h0, upperAddrOe, upperAddrPins});
        chk("pd strobe", 8'h0, {7'h0, aleQs0Pin});
        @(posedge clk);
        busHold <= 1'b1;
        @(posedge clk);
        // Strobe low from hold; status stays driven by powerdown
        #1 chk("both oe", 8'h3,
               {5'h0, aleQs0Pin, upperAddrOe, cycleStatusOe});
        @(posedge clk);
        busHold   <= 1'b0;
        powerDown <= 1'b0;
        repeat (3) @(posedge clk);
        $display("hold and powerdown test done");
    endtask

    // Reset in mid-run floats status and lowers the strobe
    task automatic test_reset();
        run_cycle(20'h3c0de, 3'h4, 1'b0);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1 chk("rst pins", 8'h0, {4'h0, cycleStatusOe, upperAddrOe,
            aleQs0Pin, cycReady});
        repeat (2) @(posedge clk);
        run_cycle(20'h71234, 3'h6, 1'b1);
        $display("reset test done");
    endtask

    // Verdict in one place
    task automatic end_of_test();
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog; the tests need about 76 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("unexpected timeout: expected done, seen running");
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        test_cycles();
        test_queue();
        test_hold_power();
        test_reset();
        end_of_test();
    end
endmodule
